// File: design/otpg_regs.vh
`ifndef OTPG_REGS_VH
`define OTPG_REGS_VH
// register indices; the byte address is four times the index
`define OTPG_ADDR_W 10
`define OTPG_IDX_CTRL 8'h90
`define OTPG_IDX_LOW01 8'h92
`define OTPG_IDX_LOW23 8'h93
`define OTPG_IDX_LOW45 8'h94
`define OTPG_IDX_LOW67 8'h95
`define OTPG_IDX_HIGH 8'h96
`define OTPG_IDX_STATUS 8'h97
// test control fields
`define OTPG_CTRL_EN 0
`define OTPG_CTRL_INC 1
`define OTPG_CTRL_PRBS 2
`define OTPG_CTRL_FRAME 3
`define OTPG_CTRL_W 4
// reset values
`define OTPG_RST_CTRL 4'h0
`define OTPG_RST_LOW01 16'h0100
`define OTPG_RST_LOW23 16'h0302
`define OTPG_RST_LOW45 16'h0504
`define OTPG_RST_LOW67 16'h0706
`define OTPG_RST_HIGH 16'h0000
// pattern limits
`define OTPG_WORD_MAX 10'h3ff
`define OTPG_PRBS_SEED 10'h001
`endif

// File: design/otpg_top.v
`timescale 1ns/1ps
`default_nettype none
`include "otpg_regs.vh"
module otpg_top #(
  parameter LANES = 32,
  parameter GROUPS = 8,
  parameter WORD_W = 10
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [`OTPG_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_ff,
  // link clock and normal pixel stream
  input wire link_clk,
  input wire [LANES*WORD_W-1:0] pix_data,
  input wire pix_frame_sync,
  input wire pix_line_valid,
  // outgoing lanes
  output reg [LANES*WORD_W-1:0] lane_data_ff,
  output reg lane_frame_sync_ff,
  output reg lane_line_valid_ff
);
  localparam [`OTPG_ADDR_W-1:0] A_CTRL = {`OTPG_IDX_CTRL, 2'b00};
  localparam [`OTPG_ADDR_W-1:0] A_L01 = {`OTPG_IDX_LOW01, 2'b00};
  localparam [`OTPG_ADDR_W-1:0] A_L23 = {`OTPG_IDX_LOW23, 2'b00};
  localparam [`OTPG_ADDR_W-1:0] A_L45 = {`OTPG_IDX_LOW45, 2'b00};
  localparam [`OTPG_ADDR_W-1:0] A_L67 = {`OTPG_IDX_LOW67, 2'b00};
  localparam [`OTPG_ADDR_W-1:0] A_HIGH = {`OTPG_IDX_HIGH, 2'b00};
  localparam [`OTPG_ADDR_W-1:0] A_STAT = {`OTPG_IDX_STATUS, 2'b00};

  reg [`OTPG_CTRL_W-1:0] ctrl_ff;
  reg [15:0] low01_ff;
  reg [15:0] low23_ff;
  reg [15:0] low45_ff;
  reg [15:0] low67_ff;
  reg [15:0] high_ff;
  reg [15:0] nxt_rdata;
  reg [2:0] lclk_sync_ff;
  reg [1:0] fs_sync_ff;
  reg [1:0] lv_sync_ff;
  reg [LANES*WORD_W-1:0] pix_s1_ff;
  reg [LANES*WORD_W-1:0] pix_s2_ff;
  reg [15:0] beat_cnt_ff;
  reg nxt_frame_sync;
  reg nxt_line_valid;
  wire [GROUPS*8-1:0] low_all;
  wire [GROUPS*WORD_W-1:0] word_all;
  wire [LANES*WORD_W-1:0] nxt_lane;
  wire [15:0] nxt_beat;
  wire lclk_rise;
  wire test_on;
  wire inc_on;
  wire prbs_on;
  wire frame_on;
  wire unframed;
  wire wr_ctrl;
  wire wr_low01;
  wire wr_low23;
  wire wr_low45;
  wire wr_low67;
  wire wr_high;
  genvar gi;
  genvar li;

  assign low_all = {low67_ff, low45_ff, low23_ff, low01_ff};
  // link clock treated as data: sampled, edge found after the second stage
  // limitation: beats shorter than two clk periods would be missed
  assign lclk_rise = lclk_sync_ff[1] & ~lclk_sync_ff[2];
  assign test_on = ctrl_ff[`OTPG_CTRL_EN];
  assign inc_on = ctrl_ff[`OTPG_CTRL_INC];
  assign prbs_on = ctrl_ff[`OTPG_CTRL_PRBS];
  assign frame_on = ctrl_ff[`OTPG_CTRL_FRAME];
  assign unframed = test_on & ~frame_on;

  // full address compare: the two low bits must be zero as well
  assign wr_ctrl = reg_wr && (reg_addr == A_CTRL);
  assign wr_low01 = reg_wr && (reg_addr == A_L01);
  assign wr_low23 = reg_wr && (reg_addr == A_L23);
  assign wr_low45 = reg_wr && (reg_addr == A_L45);
  assign wr_low67 = reg_wr && (reg_addr == A_L67);
  assign wr_high = reg_wr && (reg_addr == A_HIGH);

  // writes to unmapped indices match no register and change nothing
  always @(posedge clk)
  begin
    if (rst)
      ctrl_ff <= `OTPG_RST_CTRL;
    else if (wr_ctrl)
      ctrl_ff <= reg_wdata[`OTPG_CTRL_W-1:0];
  end

  always @(posedge clk)
  begin
    if (rst)
      low01_ff <= `OTPG_RST_LOW01;
    else if (wr_low01)
      low01_ff <= reg_wdata;
  end

  always @(posedge clk)
  begin
    if (rst)
      low23_ff <= `OTPG_RST_LOW23;
    else if (wr_low23)
      low23_ff <= reg_wdata;
  end

  always @(posedge clk)
  begin
    if (rst)
      low45_ff <= `OTPG_RST_LOW45;
    else if (wr_low45)
      low45_ff <= reg_wdata;
  end

  always @(posedge clk)
  begin
    if (rst)
      low67_ff <= `OTPG_RST_LOW67;
    else if (wr_low67)
      low67_ff <= reg_wdata;
  end

  // high bits of all groups share this one register
  always @(posedge clk)
  begin
    if (rst)
      high_ff <= `OTPG_RST_HIGH;
    else if (wr_high)
      high_ff <= reg_wdata;
  end

  always @*
  begin
    case (reg_addr)
      A_CTRL: nxt_rdata = {{(16-`OTPG_CTRL_W){1'b0}}, ctrl_ff};
      A_L01: nxt_rdata = low01_ff;
      A_L23: nxt_rdata = low23_ff;
      A_L45: nxt_rdata = low45_ff;
      A_L67: nxt_rdata = low67_ff;
      A_HIGH: nxt_rdata = high_ff;
      // status: link beat count, a sign that link_clk is alive
      A_STAT: nxt_rdata = beat_cnt_ff;
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // read data stands for one cycle per cycle of reg_rd, zero otherwise
  always @(posedge clk)
  begin
    if (rst)
      reg_rdata_ff <= 16'h0000;
    else if (reg_rd)
      reg_rdata_ff <= nxt_rdata;
    else
      reg_rdata_ff <= 16'h0000;
  end

  always @(posedge clk)
  begin
    if (rst)
      lclk_sync_ff <= 3'h0;
    else
      lclk_sync_ff <= {lclk_sync_ff[1:0], link_clk};
  end

  always @(posedge clk)
  begin
    if (rst)
      fs_sync_ff <= 2'h0;
    else
      fs_sync_ff <= {fs_sync_ff[0], pix_frame_sync};
  end

  always @(posedge clk)
  begin
    if (rst)
      lv_sync_ff <= 2'h0;
    else
      lv_sync_ff <= {lv_sync_ff[0], pix_line_valid};
  end

  // pixels get the same two stages so they stay aligned with the framing
  always @(posedge clk)
  begin
    if (rst)
      pix_s1_ff <= {LANES*WORD_W{1'b0}};
    else
      pix_s1_ff <= pix_data;
  end

  always @(posedge clk)
  begin
    if (rst)
      pix_s2_ff <= {LANES*WORD_W{1'b0}};
    else
      pix_s2_ff <= pix_s1_ff;
  end

  // per-group word generator, one step per link clock beat
  generate
    for (gi = 0; gi < GROUPS; gi = gi + 1)
    begin : grp
      wire [7:0] low_byte;
      wire [1:0] high_bits;
      wire [WORD_W-1:0] start_word;
      wire at_max;
      wire lfsr_zero;
      wire lfsr_fb;
      reg [WORD_W-1:0] word_ff;
      reg [WORD_W-1:0] nxt_word;

      assign low_byte = low_all[8*gi +: 8];
      assign high_bits = high_ff[2*gi +: 2];
      assign start_word = {high_bits, low_byte};
      assign at_max = (word_ff == `OTPG_WORD_MAX);
      assign lfsr_zero = (word_ff == {WORD_W{1'b0}});
      // feedback taps of x^10+x^7+1
      assign lfsr_fb = word_ff[WORD_W-1] ^ word_ff[WORD_W-4];
      assign word_all[gi*WORD_W +: WORD_W] = word_ff;

      // while disabled the word tracks its start, so enabling begins there
      always @*
      begin
        nxt_word = word_ff;
        if (!test_on)
        begin
          nxt_word = start_word;
        end
        else if (prbs_on)
        begin
          // zero state would lock the lfsr, so it is reseeded
          if (lfsr_zero)
            nxt_word = `OTPG_PRBS_SEED;
          else
            nxt_word = {word_ff[WORD_W-2:0], lfsr_fb};
        end
        else if (inc_on)
        begin
          if (at_max)
            nxt_word = start_word;
          else
            nxt_word = word_ff + {{(WORD_W-1){1'b0}}, 1'b1};
        end
        else
        begin
          nxt_word = start_word;
        end
      end

      // zero only until the first clock after reset loads the start value
      always @(posedge clk)
      begin
        if (rst)
          word_ff <= {WORD_W{1'b0}};
        else if (!test_on || lclk_rise)
          word_ff <= nxt_word;
      end
    end
  endgenerate

  // lane l repeats the word of group l mod GROUPS
  generate
    for (li = 0; li < LANES; li = li + 1)
    begin : lane
      wire [WORD_W-1:0] test_word;
      wire [WORD_W-1:0] pix_word;

      assign test_word = word_all[(li % GROUPS)*WORD_W +: WORD_W];
      assign pix_word = pix_s2_ff[li*WORD_W +: WORD_W];
      assign nxt_lane[li*WORD_W +: WORD_W] = test_on ? test_word : pix_word;
    end
  endgenerate

  // free-running beat count, readable as a liveness status
  assign nxt_beat = beat_cnt_ff + 16'h0001;
  always @(posedge clk)
  begin
    if (rst)
      beat_cnt_ff <= 16'h0000;
    else if (lclk_rise)
      beat_cnt_ff <= nxt_beat;
  end

  // unframed: continuous valid words, no frame sync
  always @*
  begin
    if (unframed)
      nxt_frame_sync = 1'b0;
    else
      nxt_frame_sync = fs_sync_ff[1];
  end

  always @*
  begin
    if (unframed)
      nxt_line_valid = 1'b1;
    else
      nxt_line_valid = lv_sync_ff[1];
  end

  // normal data leaves three clocks after it enters
  always @(posedge clk)
  begin
    if (rst)
      lane_data_ff <= {LANES*WORD_W{1'b0}};
    else
      lane_data_ff <= nxt_lane;
  end

  always @(posedge clk)
  begin
    if (rst)
      lane_frame_sync_ff <= 1'b0;
    else
      lane_frame_sync_ff <= nxt_frame_sync;
  end

  always @(posedge clk)
  begin
    if (rst)
      lane_line_valid_ff <= 1'b0;
    else
      lane_line_valid_ff <= nxt_line_valid;
  end
endmodule
`default_nettype wire

// File: dv/otpg_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module otpg_top_monitor #(
  parameter LANES = 32,
  parameter WORD_W = 10
) (
  // clock and register port
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_ff,
  // streams
  input wire logic [LANES*WORD_W-1:0] pix_data,
  input wire logic pix_frame_sync,
  input wire logic pix_line_valid,
  input wire logic [LANES*WORD_W-1:0] lane_data_ff,
  input wire logic lane_frame_sync_ff,
  input wire logic lane_line_valid_ff
);
  logic [3:0] ctl_ff;
  logic [3:0] age_ff;
  // lanes judged only after writes and link sync settle
  wire logic ok = age_ff == 4'hf;
  always @(posedge clk)
  begin
    age_ff <= (rst || reg_wr) ? 4'h0 : age_ff + {3'h0, !ok};
    ctl_ff <= rst ? 4'h0 : (reg_wr && reg_addr == 10'h240) ? reg_wdata[3:0] : ctl_ff;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence inc_beat;
    ok && ctl_ff[2:0] == 3'h3 ##0 $changed(lane_data_ff[9:0]);
  endsequence
  pass_thru_a: assert property (ok && !ctl_ff[0] |-> lane_data_ff == $past(pix_data, 3))
    else $error("passthrough");
  const_hold_a: assert property (ok && ctl_ff[2:0] == 3'h1 |-> $stable(lane_data_ff))
    else $error("constant moved");
  inc_step_a: assert property (inc_beat |-> lane_data_ff[9:0] == $past(lane_data_ff[9:0]) + 10'h1
    || $past(lane_data_ff[9:0]) == 10'h3ff) else $error("bad step");
  unframed_a: assert property (ok && ctl_ff[0] && !ctl_ff[3]
    |-> !lane_frame_sync_ff && lane_line_valid_ff) else $error("unframed sync");
  framed_a: assert property (ok && ctl_ff[0] && ctl_ff[3]
    |-> lane_frame_sync_ff == $past(pix_frame_sync, 3)) else $error("framed sync");
  framed_valid_a: assert property (ok && ctl_ff[0] && ctl_ff[3]
    |-> lane_line_valid_ff == $past(pix_line_valid, 3)) else $error("framed valid");
  group_copy_a: assert property (ok && ctl_ff[0] |-> lane_data_ff[79:0] == lane_data_ff[159:80]
    && lane_data_ff[159:0] == lane_data_ff[319:160]) else $error("group copy");
  ctrl_read_a: assert property (reg_rd && reg_addr == 10'h240 |=> reg_rdata_ff == {12'h0, ctl_ff})
    else $error("ctrl read");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == 16'h0)
    else $error("read idle");
endmodule
bind otpg_top otpg_top_monitor #(.LANES(LANES), .WORD_W(WORD_W)) u_otpg_top_monitor (.clk(clk),
  .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .pix_data(pix_data), .pix_frame_sync(pix_frame_sync),
  .pix_line_valid(pix_line_valid),
  .lane_data_ff(lane_data_ff), .lane_frame_sync_ff(lane_frame_sync_ff),
  .lane_line_valid_ff(lane_line_valid_ff));
`default_nettype wire

// File: dv/otpg_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module otpg_rx_model (
  // watched lanes
  input wire logic clk,
  input wire logic [319:0] lanes,
  // last group 0 word and count of word changes
  output logic [9:0] word,
  output logic [15:0] changes
);
  initial changes = 16'h0;
  always @(posedge clk)
  begin
    if (lanes[9:0] !== word)
    begin
      word <= lanes[9:0];
      changes <= changes + 16'h1;
    end
  end
endmodule
`default_nettype wire

// File: dv/otpg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module otpg_top_tb;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, link_clk = 0, fs_in = 0, lv_in = 0, fs, lv;
  logic [9:0] reg_addr = 10'h0, word;
  logic [15:0] reg_wdata = 16'h0, rdata, changes, hi = 16'h9c3b;
  logic [319:0] pix_data = 320'h0, lanes;
  int errors = 0, comparisons = 0;
  otpg_top u_otpg_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata), .link_clk(link_clk),
    .pix_data(pix_data), .pix_frame_sync(fs_in), .pix_line_valid(lv_in),
    .lane_data_ff(lanes), .lane_frame_sync_ff(fs), .lane_line_valid_ff(lv));
  otpg_rx_model u_otpg_rx_model (.clk(clk), .lanes(lanes), .word(word), .changes(changes));
  initial forever #2 clk = ~clk;
  initial forever #32 link_clk = ~link_clk;
  always @(posedge clk)
  begin
    pix_data <= {pix_data[318:0], ~pix_data[319]};
    fs_in <= pix_data[5];
    lv_in <= pix_data[2];
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] i, input logic [15:0] d);
    reg_addr <= {i, 2'b00};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] i, input logic [15:0] e);
    reg_addr <= {i, 2'b00};
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(rdata, e);
  endtask
  task automatic nxt(input logic [9:0] e);
    logic [15:0] c;
    c = changes;
    for (int n = 0; n < 64 && changes == c; n++)
      @(posedge clk);
    chk({6'h0, word}, {6'h0, e});
  endtask
  task end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h90, 16'h0);
    rd(8'h96, 16'h0);
    for (int i = 0; i < 4; i++)
      rd(8'(8'h92 + i), {8'(2 * i + 1), 8'(2 * i)});
    wr(8'h91, 16'hffff);
    rd(8'h91, 16'h0);
    $display("reset values done");
    for (int i = 0; i < 4; i++)
      wr(8'(8'h92 + i), {8'(8'hfd - 2 * i), 8'(8'hfe - 2 * i)});
    for (int i = 0; i < 4; i++)
      rd(8'(8'h92 + i), {8'(8'hfd - 2 * i), 8'(8'hfe - 2 * i)});
    wr(8'h96, hi);
    rd(8'h96, hi);
    wr(8'h90, 16'hfff9);
    rd(8'h90, 16'h0009);
    repeat (20) @(posedge clk);
    for (int n = 0; n < 8; n++)
      chk({6'h0, lanes[10 * (n + 24) +: 10]}, {6'h0, hi[2 * n +: 2], 8'(8'hfe - n)});
    $display("constant done");
    wr(8'h90, 16'h3);
    nxt(10'h3ff);
    nxt(10'h3fe);
    nxt(10'h3ff);
    chk({14'h0, fs, lv}, 16'h1);
    $display("increment done");
    wr(8'h90, 16'h1);
    wr(8'h92, 16'h1);
    wr(8'h96, 16'h0);
    repeat (20) @(posedge clk);
    wr(8'h90, 16'h5);
    nxt(10'h002);
    nxt(10'h004);
    wr(8'h90, 16'h0);
    repeat (30) @(posedge clk);
    $display("sequence done");
    end_of_test;
  end
  initial
  begin
    #40000;
    errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
